// [core/chg_irq_bank.sv]
// charger interrupt acknowledge bank and charger configuration register
`timescale 1ns/10ps
// What this block does
// - each charger ack bit silences its matching status condition at the interrupt pin
// - after an ack, pin goes high unless another unmasked unacked condition pends
// - ack bit clears itself when its status condition goes away
// - regulator ack works alike per status bit; bit 4 always reads zero
// - both ack registers are read-only, eight bits, reset to zero
// - auto-on enabled: valid source and supply above lockout force on state
// - auto-on disabled: present source enters wait mode, converters stay off
// - restart bit clears charger timers; host writes one then zero
// - bit 5 enables timers and selects what status bit 3 reports
// - bits 4 and 3 select charge current level, reset to one
// - bit 2 limits usb current to 100 mA or 500 mA
// - usb current limit bit ignored while usb permit bit is zero
// - bit 1 permits usb charging, resets to one
// - bit 0 enables all charging, resets to one
// - with both sources valid, wall input is chosen
// - configuration at 07h, eight bits read/write, reset 1Bh
// - rising regulator status bit other than bit 4 drives interrupt low unless masked
// - all mask bits reset to one
// - current field: 11 full, 10 three quarters, 01 half, 00 quarter
module chg_irq_bank (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port from the serial interface, same clock
  input wire chg_irq_pkg::reg_req_s req,
  output logic [7:0] rdata_q,
  // charger and regulator condition inputs from analog pins
  input wire logic [7:0] charger_cond_raw,
  input wire logic [7:0] regulator_cond_raw,
  input wire logic taper_comparator_raw,
  input wire logic taper_timer_done,
  input wire logic wall_input_valid_raw,
  input wire logic usb_valid_raw,
  input wire logic supply_above_lockout_raw,
  // charger control outputs
  output chg_irq_pkg::chg_ctrl_s ctrl_q,
  // interrupt pin, open drain: oe low drives low
  output logic irq_out,
  output logic irq_oe_n
);
  logic [7:0] chg_s1_q, chg_s2_q, reg_s1_q, reg_s2_q, reg_prev_q;
  logic [2:0] misc_s1_q, misc_s2_q;
  logic [7:0] chg_stat, reg_stat;
  logic [7:0] chg_mask_q, reg_mask_q, chg_ack_q, reg_ack_q, cfg_q;
  logic [7:0] chg_lat_q, reg_lat_q;
  logic [15:0] pend, pick;
  logic [15:0] shown_q;
  logic wall_ok, usb_ok, supply_ok, src_present;
  chg_irq_pkg::chg_ctrl_s ctrl_d;
  logic [7:0] rdata_d;

  // input synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chg_s1_q <= 8'h00;
      chg_s2_q <= 8'h00;
      reg_s1_q <= 8'h00;
      reg_s2_q <= 8'h00;
      misc_s1_q <= 3'h0;
      misc_s2_q <= 3'h0;
    end else begin
      chg_s1_q <= {charger_cond_raw[7:4], 1'b0, charger_cond_raw[2:0]};
      chg_s2_q <= chg_s1_q;
      reg_s1_q <= regulator_cond_raw & chg_irq_pkg::REG_ACK_VALID;
      reg_s2_q <= reg_s1_q;
      misc_s1_q <= {wall_input_valid_raw, usb_valid_raw, supply_above_lockout_raw};
      misc_s2_q <= misc_s1_q;
    end
  end

  logic taper_s1_q, taper_s2_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      taper_s1_q <= 1'b0;
      taper_s2_q <= 1'b0;
    end else begin
      taper_s1_q <= taper_comparator_raw;
      taper_s2_q <= taper_s1_q;
    end
  end

  assign wall_ok = misc_s2_q[2];
  assign usb_ok = misc_s2_q[1];
  assign supply_ok = misc_s2_q[0];
  assign src_present = wall_ok | usb_ok;

  always_comb begin
    chg_stat = chg_s2_q;
    chg_stat[chg_irq_pkg::TAPER_BIT] = cfg_q[chg_irq_pkg::CFG_TIMER_EN] ? taper_timer_done
                                                                          : taper_s2_q;
  end
  assign reg_stat = reg_s2_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_prev_q <= 8'h00;
    end else begin
      reg_prev_q <= reg_stat;
    end
  end

  // masks reset to all ones, host writable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chg_mask_q <= chg_irq_pkg::RST_MASK;
      reg_mask_q <= chg_irq_pkg::RST_MASK;
    end else if (req.wr) begin
      if (req.addr == chg_irq_pkg::OFF_CHARGER_MASK) begin
        chg_mask_q <= req.wdata;
      end
      if (req.addr == chg_irq_pkg::OFF_REGULATOR_MASK) begin
        reg_mask_q <= req.wdata;
      end
    end
  end

  // latch regulator rising edges, charger conditions as levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_lat_q <= 8'h00;
      chg_lat_q <= 8'h00;
    end else begin
      reg_lat_q <= (reg_lat_q & reg_stat) | (reg_stat & ~reg_prev_q);
      chg_lat_q <= chg_stat;
    end
  end

  assign pend = {chg_lat_q & ~chg_mask_q & ~chg_ack_q,
                 reg_lat_q & ~reg_mask_q & ~reg_ack_q & chg_irq_pkg::REG_ACK_VALID};

  irq_pick #(.W(16)) u_pick (
    .pend(pend),
    .pick(pick)
  );

  // shown condition: hold until it leaves pending, then take the next
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shown_q <= 16'h0000;
    end else if ((shown_q & pend) == 16'h0000) begin
      shown_q <= pick;
    end
  end

  // acks track status, set from host read of status, clear on removal
  logic rd_chg_stat, rd_reg_stat;
  assign rd_chg_stat = req.rd && (req.addr == chg_irq_pkg::OFF_CHARGER_STATUS);
  assign rd_reg_stat = req.rd && (req.addr == chg_irq_pkg::OFF_REGULATOR_STATUS);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chg_ack_q <= chg_irq_pkg::RST_ACK;
      reg_ack_q <= chg_irq_pkg::RST_ACK;
    end else begin
      chg_ack_q <= (chg_ack_q | (rd_chg_stat ? shown_q[15:8] : 8'h00)) & chg_lat_q;
      reg_ack_q <= (reg_ack_q | (rd_reg_stat ? shown_q[7:0] : 8'h00)) & reg_lat_q
                   & chg_irq_pkg::REG_ACK_VALID;
    end
  end

  // pin low while any condition pends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_oe_n <= 1'b1;
    end else begin
      irq_oe_n <= (pend == 16'h0000);
    end
  end
  assign irq_out = 1'b0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= chg_irq_pkg::RST_CONFIG;
    end else if (req.wr && req.addr == chg_irq_pkg::OFF_CHARGER_CONFIG) begin
      cfg_q <= req.wdata;
    end
  end

  always_comb begin
    ctrl_d = '0;
    ctrl_d.force_on = !cfg_q[chg_irq_pkg::CFG_AUTO_ON_DIS] && src_present && supply_ok;
    ctrl_d.wait_mode = cfg_q[chg_irq_pkg::CFG_AUTO_ON_DIS] && src_present;
    ctrl_d.restart = cfg_q[chg_irq_pkg::CFG_RESTART];
    ctrl_d.timers_en = cfg_q[chg_irq_pkg::CFG_TIMER_EN];
    ctrl_d.cur_level = chg_irq_pkg::cur_level_e'(cfg_q[chg_irq_pkg::CFG_CUR_MSB:
                                                       chg_irq_pkg::CFG_CUR_LSB]);
    if (!cfg_q[chg_irq_pkg::CFG_CHARGE_EN]) begin
      ctrl_d.source = chg_irq_pkg::SRC_NONE;
    end else if (wall_ok) begin
      ctrl_d.source = chg_irq_pkg::SRC_WALL;
    end else if (usb_ok && cfg_q[chg_irq_pkg::CFG_USB_PERMIT]) begin
      ctrl_d.source = chg_irq_pkg::SRC_USB;
    end else begin
      ctrl_d.source = chg_irq_pkg::SRC_NONE;
    end
    // usb limit only while usb permitted
    ctrl_d.usb_limit_500 = cfg_q[chg_irq_pkg::CFG_USB_PERMIT] &&
                           cfg_q[chg_irq_pkg::CFG_USB_500];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // read mux
  always_comb begin
    unique case (req.addr)
      chg_irq_pkg::OFF_CHARGER_STATUS: rdata_d = chg_lat_q;
      chg_irq_pkg::OFF_REGULATOR_STATUS: rdata_d = reg_stat;
      chg_irq_pkg::OFF_CHARGER_MASK: rdata_d = chg_mask_q;
      chg_irq_pkg::OFF_REGULATOR_MASK: rdata_d = reg_mask_q;
      chg_irq_pkg::OFF_CHARGER_ACK: rdata_d = chg_ack_q;
      chg_irq_pkg::OFF_REGULATOR_ACK: rdata_d = reg_ack_q & chg_irq_pkg::REG_ACK_VALID;
      chg_irq_pkg::OFF_CHARGER_CONFIG: rdata_d = cfg_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (req.rd) begin
      rdata_q <= rdata_d;
    end
  end

  // a fresh regulator edge reaches the pin two edges later
  sequence s_reg0_fresh_edge;
    reg_stat[0] && !reg_prev_q[0] && !reg_mask_q[0] && !reg_ack_q[0];
  endsequence
  sequence s_pin_low_next;
    ##1 !irq_oe_n;
  endsequence
  // a host read of a status register acknowledges the shown condition
  sequence s_chg7_read_while_shown;
    rd_chg_stat && shown_q[15] && chg_lat_q[7];
  endsequence
  sequence s_reg0_read_while_shown;
    rd_reg_stat && shown_q[0] && reg_lat_q[0];
  endsequence

  chk_ack_bit4_zero: assert property (@(posedge clk) disable iff (!rst_n)
    reg_ack_q[4] == 1'b0)
    else $error("regulator ack bit 4 set");
  chk_ack_clears_off: assert property (@(posedge clk) disable iff (!rst_n)
    !chg_lat_q[0] |=> !chg_ack_q[0])
    else $error("ack not cleared");
  chk_irq_release: assert property (@(posedge clk) disable iff (!rst_n)
    (pend == 16'h0000) |=> irq_oe_n)
    else $error("pin low with nothing pending");
  chk_irq_assert: assert property (@(posedge clk) disable iff (!rst_n)
    (pend != 16'h0000) |=> !irq_oe_n)
    else $error("pin high while pending");
  chk_wall_priority: assert property (@(posedge clk) disable iff (!rst_n)
    (wall_ok && cfg_q[0]) |=> ctrl_q.source == chg_irq_pkg::SRC_WALL)
    else $error("wall not chosen");
  chk_charge_block: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg_q[0] |=> ctrl_q.source == chg_irq_pkg::SRC_NONE)
    else $error("charging while disabled");
  chk_usb_block: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg_q[1] && !wall_ok) |=> ctrl_q.source != chg_irq_pkg::SRC_USB)
    else $error("usb charging not permitted");
  chk_usb_limit_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg_q[1] |=> !ctrl_q.usb_limit_500)
    else $error("usb limit not ignored");
  chk_auto_on_wait: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_q.force_on |-> !ctrl_q.wait_mode)
    else $error("on and wait together");
  chk_reg_edge_irq: assert property (@(posedge clk) disable iff (!rst_n)
    s_reg0_fresh_edge |=> s_pin_low_next)
    else $error("rising edge missed");
  chk_cfg_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && (req.addr == chg_irq_pkg::OFF_CHARGER_CONFIG))
    |=> (cfg_q == $past(req.wdata)))
    else $error("configuration write lost");
  chk_chg_ack_ro: assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && !req.rd && (req.addr == chg_irq_pkg::OFF_CHARGER_ACK))
    |=> ((chg_ack_q & ~$past(chg_ack_q)) == 8'h00))
    else $error("charger ack written by host");
  chk_reg_ack_ro: assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && !req.rd && (req.addr == chg_irq_pkg::OFF_REGULATOR_ACK))
    |=> ((reg_ack_q & ~$past(reg_ack_q)) == 8'h00))
    else $error("regulator ack written by host");
  chk_read_acks_chg: assert property (@(posedge clk) disable iff (!rst_n)
    s_chg7_read_while_shown |=> chg_ack_q[7])
    else $error("shown charger condition not acknowledged");
  chk_read_acks_reg: assert property (@(posedge clk) disable iff (!rst_n)
    s_reg0_read_while_shown |=> reg_ack_q[0])
    else $error("shown regulator condition not acknowledged");
  chk_ack_follows_off: assert property (@(posedge clk) disable iff (!rst_n)
    !chg_stat[7] |-> ##2 !chg_ack_q[7])
    else $error("ack outlived its condition");
  chk_shown_onehot: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot0(shown_q))
    else $error("more than one condition shown");
  chk_shown_holds: assert property (@(posedge clk) disable iff (!rst_n)
    ((shown_q & pend) != 16'h0000) |=> (shown_q == $past(shown_q)))
    else $error("shown condition dropped early");
  chk_charger_first: assert property (@(posedge clk) disable iff (!rst_n)
    (((shown_q & pend) == 16'h0000) && (pend[15:8] != 8'h00))
    |=> (shown_q[7:0] == 8'h00))
    else $error("regulator shown before charger");
  chk_force_on: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg_q[chg_irq_pkg::CFG_AUTO_ON_DIS] && src_present && supply_ok)
    |=> ctrl_q.force_on)
    else $error("auto-on did not force on");
  chk_wait_mode: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_q[chg_irq_pkg::CFG_AUTO_ON_DIS] && src_present)
    |=> (ctrl_q.wait_mode && !ctrl_q.force_on))
    else $error("wait mode not entered");
  chk_restart_mirror: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> (ctrl_q.restart == $past(cfg_q[chg_irq_pkg::CFG_RESTART])))
    else $error("restart does not follow its bit");
  chk_taper_timer: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_q[chg_irq_pkg::CFG_TIMER_EN] |=> (chg_lat_q[3] == $past(taper_timer_done)))
    else $error("taper bit not from timer");
  chk_taper_comp: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg_q[chg_irq_pkg::CFG_TIMER_EN] |=> (chg_lat_q[3] == $past(taper_s2_q)))
    else $error("taper bit not from comparator");
  chk_cur_full: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_q[chg_irq_pkg::CFG_CUR_MSB:chg_irq_pkg::CFG_CUR_LSB] == 2'h3)
    |=> (ctrl_q.cur_level == chg_irq_pkg::CUR_FULL))
    else $error("full current not selected");
  chk_cur_three_q: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_q[chg_irq_pkg::CFG_CUR_MSB:chg_irq_pkg::CFG_CUR_LSB] == 2'h2)
    |=> (ctrl_q.cur_level == chg_irq_pkg::CUR_THREE_Q))
    else $error("three quarter current not selected");
  chk_usb_limit_on: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_q[2] && cfg_q[1]) |=> ctrl_q.usb_limit_500)
    else $error("usb limit not raised");
  chk_usb_source: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_q[0] && cfg_q[1] && usb_ok && !wall_ok)
    |=> (ctrl_q.source == chg_irq_pkg::SRC_USB))
    else $error("usb charging not taken");
endmodule

// [core/irq_pick.sv]
// picks the highest priority pending condition as a one-hot choice
`timescale 1ns/10ps
module irq_pick #(
  parameter int W = 16
) (
  // pending vector, bit W-1 highest
  input wire logic [W-1:0] pend,
  // one-hot choice
  output logic [W-1:0] pick
);
  // refuse a width the priority loop cannot serve
  if (W < 1) begin
    $error("irq_pick width must be positive");
  end

  always_comb begin
    pick = '0;
    for (int i = 0; i < W; i++) begin
      if (pend[i]) begin
        pick = '0;
        pick[i] = 1'b1;
      end
    end
  end
endmodule

// [dv/host_model.sv]
// register-port model of the application processor
`timescale 1ns/10ps
module host_model (
  // clock
  input wire logic clk,
  // register request toward the bank
  output chg_irq_pkg::reg_req_s req,
  // read data from the bank
  input wire logic [7:0] rdata_q
);
  initial req = '0;
  // one-cycle write pulse; released fields show inverted values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    #1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    @(posedge clk);
    #1 d = rdata_q;
  endtask
endmodule

// [dv/tb_chg_irq_bank.sv]
// self-checking bench for the charger interrupt and configuration bank
`timescale 1ns/10ps
module tb_chg_irq_bank;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  chg_irq_pkg::reg_req_s req;
  chg_irq_pkg::chg_ctrl_s ctrl_q;
  logic [7:0] rdata_q;
  logic [7:0] v;
  logic [7:0] chg_raw = 8'h00;
  logic [7:0] reg_raw = 8'h00;
  logic taper_raw = 1'b0;
  logic taper_done = 1'b0;
  logic wall = 1'b0;
  logic usb = 1'b0;
  logic supply = 1'b1;
  logic irq_out;
  logic irq_oe_n;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  chg_irq_bank uut (.clk(clk), .rst_n(rst_n), .req(req), .rdata_q(rdata_q),
    .charger_cond_raw(chg_raw), .regulator_cond_raw(reg_raw),
    .taper_comparator_raw(taper_raw), .taper_timer_done(taper_done),
    .wall_input_valid_raw(wall), .usb_valid_raw(usb), .supply_above_lockout_raw(supply),
    .ctrl_q(ctrl_q), .irq_out(irq_out), .irq_oe_n(irq_oe_n));
  host_model host (.clk(clk), .req(req), .rdata_q(rdata_q));
  task automatic finish_test;
    if (bad_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, v);
    chk($sformatf("reg %h", a), {1'b0, exp}, {1'b0, v});
  endtask
  task automatic wait_irq(input logic exp);
    for (int i = 0; i < 12 && irq_oe_n !== exp; i++) settle(1);
    chk("irq_oe_n", {8'h00, exp}, {8'h00, irq_oe_n});
  endtask
  // write config, apply sources, compare masked control fields
  task automatic ctl(input logic [7:0] cfg, input logic w, input logic u,
                     input logic [8:0] m, input logic [8:0] e);
    host.wr(8'h07, cfg);
    wall = w;
    usb = u;
    settle(6);
    chk("ctrl_q", e & m, ctrl_q & m);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    rchk(8'h07, 8'h1B);
    rchk(8'h05, 8'h00);
    rchk(8'h06, 8'h00);
    rchk(8'h03, 8'hFF);
    rchk(8'h04, 8'hFF);
    host.wr(8'h05, 8'hFF);
    host.wr(8'h06, 8'hFF);
    rchk(8'h05, 8'h00);
    rchk(8'h06, 8'h00);
    chg_raw = 8'h04;
    reg_raw = 8'h01;
    settle(8);
    chk("irq masked", 9'h001, {8'h00, irq_oe_n});
    chg_raw = 8'h00;
    reg_raw = 8'h00;
    ctl(8'h1B, 1'b1, 1'b1, 9'h1FF, 9'h11E);
    ctl(8'h9F, 1'b0, 1'b1, 9'h1FF, 9'h09B);
    ctl(8'h65, 1'b0, 1'b1, 9'h1FF, 9'h160);
    ctl(8'h4A, 1'b1, 1'b1, 9'h07E, 9'h048);
    supply = 1'b0;
    ctl(8'h1B, 1'b1, 1'b0, 9'h1FF, 9'h01E);
    supply = 1'b1;
    ctl(8'h13, 1'b1, 1'b0, 9'h07E, 9'h016);
    rchk(8'h07, 8'h13);
    taper_raw = 1'b1;
    settle(6);
    rchk(8'h01, 8'h08);
    host.wr(8'h07, 8'h33);
    settle(2);
    rchk(8'h01, 8'h00);
    taper_done = 1'b1;
    settle(2);
    rchk(8'h01, 8'h08);
    taper_done = 1'b0;
    taper_raw = 1'b0;
    host.wr(8'h03, 8'h7B);
    chg_raw = 8'h84;
    wait_irq(1'b0);
    chk("irq_out", 9'h000, {8'h00, irq_out});
    host.rd(8'h01, v);
    rchk(8'h05, 8'h80);
    chk("irq next", 9'h000, {8'h00, irq_oe_n});
    host.rd(8'h01, v);
    rchk(8'h05, 8'h84);
    wait_irq(1'b1);
    chg_raw = 8'h04;
    settle(6);
    rchk(8'h05, 8'h04);
    chg_raw = 8'h84;
    wait_irq(1'b0);
    host.rd(8'h01, v);
    wait_irq(1'b1);
    host.wr(8'h04, 8'h00);
    reg_raw = 8'h10;
    settle(8);
    chk("irq rsvd", 9'h001, {8'h00, irq_oe_n});
    reg_raw = 8'h11;
    wait_irq(1'b0);
    host.rd(8'h02, v);
    rchk(8'h06, 8'h01);
    wait_irq(1'b1);
    reg_raw = 8'h13;
    wait_irq(1'b0);
    rst_n = 1'b0;
    settle(1);
    chk("irq rst", 9'h001, {8'h00, irq_oe_n});
    rst_n = 1'b1;
    settle(6);
    chk("irq after rst", 9'h001, {8'h00, irq_oe_n});
    rchk(8'h07, 8'h1B);
    rchk(8'h04, 8'hFF);
    rchk(8'h06, 8'h00);
    finish_test();
  end
endmodule

// [shared/chg_irq_pkg.sv]
// constants, layouts and types for the charger interrupt and configuration bank
package chg_irq_pkg;
  localparam int REG_W = 8;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CHARGER_STATUS = 8'h01;
  localparam logic [7:0] OFF_REGULATOR_STATUS = 8'h02;
  localparam logic [7:0] OFF_CHARGER_MASK = 8'h03;
  localparam logic [7:0] OFF_REGULATOR_MASK = 8'h04;
  localparam logic [7:0] OFF_CHARGER_ACK = 8'h05;
  localparam logic [7:0] OFF_REGULATOR_ACK = 8'h06;
  localparam logic [7:0] OFF_CHARGER_CONFIG = 8'h07;
  localparam logic [7:0] RST_ACK = 8'h00;
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic [7:0] RST_CONFIG = 8'h1B;
  localparam logic [7:0] REG_ACK_VALID = 8'hEF;
  localparam int CFG_AUTO_ON_DIS = 7;
  localparam int CFG_RESTART = 6;
  localparam int CFG_TIMER_EN = 5;
  localparam int CFG_CUR_MSB = 4;
  localparam int CFG_CUR_LSB = 3;
  localparam int CFG_USB_500 = 2;
  localparam int CFG_USB_PERMIT = 1;
  localparam int CFG_CHARGE_EN = 0;
  localparam int TAPER_BIT = 3;

  typedef enum logic [1:0] {
    CUR_QUARTER = 2'h0,
    CUR_HALF = 2'h1,
    CUR_THREE_Q = 2'h2,
    CUR_FULL = 2'h3
  } cur_level_e;

  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_USB = 2'h1,
    SRC_WALL = 2'h3
  } chg_src_e;

  typedef struct packed {
    logic force_on;
    logic wait_mode;
    logic restart;
    logic timers_en;
    cur_level_e cur_level;
    chg_src_e source;
    logic usb_limit_500;
  } chg_ctrl_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
endpackage
